// ### rtl/dcc_dma_count_config.sv
`timescale 1ns/100ps
// Functional notes
// - 32-bit byte count, four byte fields
// - low count bytes reset to zero
// - two-byte configuration register at 38H
// - bit 14 ignores drive ready in every mode
// - bit 13 one selects disk interface
// - bit 13 zero selects generic mode
// - bits 12-11 pick UDMA/MDMA timing 0-2
// - timing code 3 uses strobe register, MDMA
// - bits 10-8 pick PIO mode 0-4
// - bit 7 disables counter, slave only
// - burst field acts in generic slave only
// - code 0 holds request until end
// - code 1 pulses request per beat
// - codes 2-6 pulse per burst
// - bit 0 selects bus width, resets 16
// - request undriven until configuration written
// - request only when fifo can serve
// - counter loads when top byte written
module dcc_dma_count_config
  import dcc_pkg::*;
(
  input wire logic clock_i, // 10 MHz device clock
  input wire logic srst_i, // power-on or bus reset
  input wire logic [7:0] reg_addr_i, // register byte address
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [7:0] reg_wdata_i, // register write byte
  output logic [7:0] reg_rdata_o, // register read byte
  input wire logic master_mode_i, // dma core is bus master
  input wire logic xfer_start_i, // start a transfer
  input wire logic xfer_stop_i, // abort a transfer
  input wire logic xfer_beat_i, // one byte or word moved
  input wire logic fifo_ok_i, // fifo space (write) or data (read)
  input wire logic iordy_i, // drive ready pin, asynchronous
  output logic dma_request_line_o, // request level
  output logic dma_request_line_oe_o, // request pin enable
  output logic xfer_active_o, // transfer running
  output logic xfer_done_o, // count reached zero, one cycle
  output logic count_enabled_o, // counter in use
  output logic ready_ok_o, // data phase may proceed
  output logic skip_ready_wait_o, // drive ready ignored
  output logic disk_interface_select_o, // disk interface mode
  output logic generic_slave_dma_o, // generic slave mode active
  output logic [1:0] udma_timing_o, // UDMA/MDMA timing mode
  output logic strobe_reg_timing_o, // custom strobe timing in use
  output logic [2:0] programmed_io_timing_o, // PIO timing mode
  output logic pio_code_bad_o, // reserved PIO code programmed
  output logic [1:0] strobe_select_o, // handshake strobe select
  output logic wide_bus_o // 16-bit data bus
);
  logic [15:0] cfg;
  logic cfg_written;
  logic wr_cfg_lo, wr_cfg_hi;
  logic wr_b1, wr_b2, wr_b3, wr_b4;

  logic [23:0] shadow_q;
  logic [31:0] byte_count_register_q;
  logic [31:0] count_d;
  logic [31:0] step;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic active_q;
  logic done_q;
  logic beat;
  logic count_end;
  logic req;
  logic iordy_meta_q, iordy_sync_q;

  // register decode
  assign wr_b1 = reg_wr_i && (reg_addr_i == DCC_ADDR_CNT_B1);
  assign wr_b2 = reg_wr_i && (reg_addr_i == DCC_ADDR_CNT_B2);
  assign wr_b3 = reg_wr_i && (reg_addr_i == DCC_ADDR_CNT_B3);
  assign wr_b4 = reg_wr_i && (reg_addr_i == DCC_ADDR_CNT_B4);
  assign wr_cfg_lo = reg_wr_i && (reg_addr_i == DCC_ADDR_CFG_LO);
  assign wr_cfg_hi = reg_wr_i && (reg_addr_i == DCC_ADDR_CFG_HI);

  dcc_cfg_reg u_cfg (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_lo_i(wr_cfg_lo),
    .wr_hi_i(wr_cfg_hi),
    .wdata_i(reg_wdata_i),
    .cfg_o(cfg),
    .written_o(cfg_written)
  );

  // configuration fields
  assign skip_ready_wait_o = cfg[DCC_BIT_SKIP_READY];
  assign disk_interface_select_o = cfg[DCC_BIT_DISK_IF];
  assign generic_slave_dma_o = !cfg[DCC_BIT_DISK_IF] && !master_mode_i;
  assign udma_timing_o = cfg[DCC_BIT_UDMA_HI:DCC_BIT_UDMA_LO];
  assign strobe_reg_timing_o = cfg[DCC_BIT_DISK_IF] &&
                               (udma_timing_o == DCC_TIMING_CUSTOM);
  assign programmed_io_timing_o = cfg[DCC_BIT_PIO_HI:DCC_BIT_PIO_LO];
  assign pio_code_bad_o = (programmed_io_timing_o > DCC_PIO_MAX);
  assign strobe_select_o = cfg[DCC_BIT_STROBE_HI:DCC_BIT_STROBE_LO];
  assign wide_bus_o = cfg[DCC_BIT_WIDTH];

  // counter may be switched off only in generic slave mode
  assign count_enabled_o = !(cfg[DCC_BIT_CNT_DIS] && generic_slave_dma_o);

  // drive ready pin synchroniser
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      iordy_meta_q <= 1'b0;
      iordy_sync_q <= 1'b0;
    end else begin
      iordy_meta_q <= iordy_i;
      iordy_sync_q <= iordy_meta_q;
    end
  end

  assign ready_ok_o = skip_ready_wait_o || iordy_sync_q;

  // byte counting
  assign beat = xfer_beat_i && active_q;
  assign step = wide_bus_o ? DCC_STEP_16BIT : DCC_STEP_8BIT;
  assign count_end = beat && count_enabled_o && (byte_count_register_q <= step);
  assign count_d = (byte_count_register_q <= step) ? DCC_CNT_RESET
                                                    : byte_count_register_q - step;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shadow_q <= DCC_CNT_RESET[23:0];
      byte_count_register_q <= DCC_CNT_RESET;
    end else begin
      if (wr_b1) begin
        shadow_q[7:0] <= reg_wdata_i;
      end
      if (wr_b2) begin
        shadow_q[15:8] <= reg_wdata_i;
      end
      if (wr_b3) begin
        shadow_q[23:16] <= reg_wdata_i;
      end
      if (wr_b4) begin
        byte_count_register_q <= {reg_wdata_i, shadow_q};
      end else if (beat && count_enabled_o) begin
        byte_count_register_q <= count_d;
      end
    end
  end

  // transfer run flag and end pulse
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      active_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= count_end;
      if (xfer_stop_i || count_end) begin
        active_q <= 1'b0;
      end else if (xfer_start_i) begin
        active_q <= 1'b1;
      end
    end
  end

  assign xfer_active_o = active_q;
  assign xfer_done_o = done_q;

  // request generation, generic slave mode only
  dcc_req_gen u_req (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .go_i(active_q && generic_slave_dma_o && !count_end),
    .fifo_ok_i(fifo_ok_i),
    .beat_i(beat),
    .burst_i(cfg[DCC_BIT_BURST_HI:DCC_BIT_BURST_LO]),
    .req_o(req)
  );

  assign dma_request_line_o = req && cfg_written;
  assign dma_request_line_oe_o = cfg_written;

  // read back: live count and configuration
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      DCC_ADDR_CNT_B1: rdata_d = byte_count_register_q[7:0];
      DCC_ADDR_CNT_B2: rdata_d = byte_count_register_q[15:8];
      DCC_ADDR_CNT_B3: rdata_d = byte_count_register_q[23:16];
      DCC_ADDR_CNT_B4: rdata_d = byte_count_register_q[31:24];
      DCC_ADDR_CFG_LO: rdata_d = cfg[7:0];
      DCC_ADDR_CFG_HI: rdata_d = cfg[15:8];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
endmodule

// ### rtl/dcc_pkg.sv
package dcc_pkg;
  localparam logic [7:0] DCC_ADDR_CNT_B1 = 8'h34;
  localparam logic [7:0] DCC_ADDR_CNT_B2 = 8'h35;
  localparam logic [7:0] DCC_ADDR_CNT_B3 = 8'h36;
  localparam logic [7:0] DCC_ADDR_CNT_B4 = 8'h37;
  localparam logic [7:0] DCC_ADDR_CFG_LO = 8'h38;
  localparam logic [7:0] DCC_ADDR_CFG_HI = 8'h39;

  localparam logic [15:0] DCC_CFG_RESET = 16'h0001;
  localparam logic [31:0] DCC_CNT_RESET = 32'h0000_0000;

  localparam int DCC_BIT_SKIP_READY = 14;
  localparam int DCC_BIT_DISK_IF = 13;
  localparam int DCC_BIT_UDMA_HI = 12;
  localparam int DCC_BIT_UDMA_LO = 11;
  localparam int DCC_BIT_PIO_HI = 10;
  localparam int DCC_BIT_PIO_LO = 8;
  localparam int DCC_BIT_CNT_DIS = 7;
  localparam int DCC_BIT_BURST_HI = 6;
  localparam int DCC_BIT_BURST_LO = 4;
  localparam int DCC_BIT_STROBE_HI = 3;
  localparam int DCC_BIT_STROBE_LO = 2;
  localparam int DCC_BIT_WIDTH = 0;

  localparam logic [1:0] DCC_TIMING_CUSTOM = 2'h3;
  localparam logic [2:0] DCC_PIO_MAX = 3'h4;

  localparam logic [2:0] DCC_BURST_CONT = 3'h0;
  localparam logic [2:0] DCC_BURST_1 = 3'h1;
  localparam logic [2:0] DCC_BURST_2 = 3'h2;
  localparam logic [2:0] DCC_BURST_4 = 3'h3;
  localparam logic [2:0] DCC_BURST_8 = 3'h4;
  localparam logic [2:0] DCC_BURST_12 = 3'h5;
  localparam logic [2:0] DCC_BURST_16 = 3'h6;

  localparam logic [31:0] DCC_STEP_8BIT = 32'h0000_0001;
  localparam logic [31:0] DCC_STEP_16BIT = 32'h0000_0002;

  // beats per request; zero means hold the request continuously
  function automatic logic [4:0] dcc_burst_len(input logic [2:0] code);
    logic [4:0] len;
    len = 5'h01;
    unique case (code)
      DCC_BURST_CONT: len = 5'h00;
      DCC_BURST_1: len = 5'h01;
      DCC_BURST_2: len = 5'h02;
      DCC_BURST_4: len = 5'h04;
      DCC_BURST_8: len = 5'h08;
      DCC_BURST_12: len = 5'h0c;
      DCC_BURST_16: len = 5'h10;
      default: len = 5'h01;
    endcase
    return len;
  endfunction
endpackage

// ### rtl/dcc_cfg_reg.sv
`timescale 1ns/100ps
module dcc_cfg_reg
  import dcc_pkg::*;
(
  input wire logic clock_i, // device clock
  input wire logic srst_i, // reset, power-on or bus
  input wire logic wr_lo_i, // write low byte
  input wire logic wr_hi_i, // write high byte
  input wire logic [7:0] wdata_i, // write byte
  output logic [15:0] cfg_o, // stored configuration
  output logic written_o // any write seen since reset
);
  logic [15:0] cfg_q;
  logic written_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_q <= DCC_CFG_RESET;
      written_q <= 1'b0;
    end else begin
      if (wr_lo_i) begin
        cfg_q[7:0] <= wdata_i;
      end
      if (wr_hi_i) begin
        cfg_q[15:8] <= wdata_i;
      end
      if (wr_lo_i || wr_hi_i) begin
        written_q <= 1'b1;
      end
    end
  end

  assign cfg_o = cfg_q;
  assign written_o = written_q;
endmodule

// ### rtl/dcc_req_gen.sv
`timescale 1ns/100ps
module dcc_req_gen
  import dcc_pkg::*;
(
  input wire logic clock_i, // device clock
  input wire logic srst_i, // reset
  input wire logic go_i, // transfer running in generic slave mode
  input wire logic fifo_ok_i, // fifo has space or data
  input wire logic beat_i, // one byte or word moved
  input wire logic [2:0] burst_i, // burst code
  output logic req_o // request level
);
  typedef enum logic [1:0] {REQ_IDLE, REQ_ON, REQ_GAP} dcc_req_state_t;

  dcc_req_state_t state_q, state_d;
  logic [4:0] beats_q, beats_d;
  logic [4:0] len;
  logic burst_end;

  assign len = dcc_burst_len(burst_i);
  assign burst_end = beat_i && (len != 5'h00) && (beats_q + 5'h01 == len);

  always_comb begin
    state_d = state_q;
    beats_d = beats_q;
    unique case (state_q)
      REQ_IDLE: begin
        beats_d = 5'h00;
        if (go_i && fifo_ok_i) begin
          state_d = REQ_ON;
        end
      end
      REQ_ON: begin
        if (!go_i || !fifo_ok_i) begin
          state_d = REQ_IDLE;
        end else if (burst_end) begin
          state_d = REQ_GAP;
        end else if (beat_i) begin
          beats_d = beats_q + 5'h01;
        end
      end
      REQ_GAP: begin
        state_d = REQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= REQ_IDLE;
      beats_q <= 5'h00;
    end else begin
      state_q <= state_d;
      beats_q <= beats_d;
    end
  end

  assign req_o = (state_q == REQ_ON);
endmodule

// ### testbench/dcc_dma_count_config_properties.sv
`timescale 1ns/100ps
module dcc_dma_count_config_properties
  import dcc_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic srst_i, // reset
  input wire logic master_mode_i, // master
  input wire logic fifo_ok_i, // fifo
  input wire logic [7:0] reg_rdata_o, // read byte
  input wire logic dma_request_line_o, // request
  input wire logic dma_request_line_oe_o, // enable
  input wire logic xfer_active_o, // active
  input wire logic xfer_done_o, // done
  input wire logic count_enabled_o, // counter on
  input wire logic ready_ok_o, // ready
  input wire logic skip_ready_wait_o, // skip
  input wire logic disk_interface_select_o, // disk
  input wire logic generic_slave_dma_o, // slave
  input wire logic [1:0] udma_timing_o, // timing
  input wire logic strobe_reg_timing_o, // strobe
  input wire logic [2:0] programmed_io_timing_o, // pio
  input wire logic pio_code_bad_o, // bad pio
  input wire logic wide_bus_o // width
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  property p_rst; $past(srst_i) |-> wide_bus_o && !dma_request_line_oe_o
    && !xfer_active_o && reg_rdata_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_gate; dma_request_line_o |-> dma_request_line_oe_o; endproperty
  a_gate: assert property (p_gate) else $error("request before config");
  property p_skip; skip_ready_wait_o |-> ready_ok_o; endproperty
  a_skip: assert property (p_skip) else $error("ready not skipped");
  property p_mode; generic_slave_dma_o == (!disk_interface_select_o && !master_mode_i); endproperty
  a_mode: assert property (p_mode) else $error("mode select wrong");
  property p_cnt; master_mode_i || disk_interface_select_o |-> count_enabled_o; endproperty
  a_cnt: assert property (p_cnt) else $error("counter off outside slave");
  property p_strb; strobe_reg_timing_o ==
    (disk_interface_select_o && udma_timing_o == DCC_TIMING_CUSTOM); endproperty
  a_strb: assert property (p_strb) else $error("strobe timing wrong");
  property p_pio; pio_code_bad_o == (programmed_io_timing_o > DCC_PIO_MAX); endproperty
  a_pio: assert property (p_pio) else $error("pio flag wrong");
  property p_done; xfer_done_o |-> !xfer_active_o ##1 !xfer_done_o; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_rise; $rose(dma_request_line_o) |->
    $past(fifo_ok_i) && $past(xfer_active_o) && $past(generic_slave_dma_o); endproperty
  a_rise: assert property (p_rise) else $error("request without cause");
  property p_drop; !fifo_ok_i |=> !dma_request_line_o; endproperty
  a_drop: assert property (p_drop) else $error("request with fifo blocked");
  c_req: cover property ($rose(dma_request_line_o));
  c_done: cover property (xfer_done_o);
  c_strb: cover property (strobe_reg_timing_o);
endmodule

// ### testbench/dcc_far_model.sv
`timescale 1ns/100ps
module dcc_far_model (
  input wire logic clock_i, // device clock
  input wire logic srst_i, // reset
  input wire logic req_i, // request pin
  input wire logic oe_i, // request pin driven
  input wire logic slow_i, // answer every other cycle
  output logic beat_o // one transfer
);
  logic tick_q;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      beat_o <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= ~tick_q;
      // an undriven pin is never taken as a request
      beat_o <= req_i && oe_i && !beat_o && (!slow_i || tick_q);
    end
  end
endmodule

// ### testbench/tb_dma_count_and_config.sv
`timescale 1ns/100ps
module tb_dma_count_and_config;
  import dcc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ms = 0, st = 0, sp = 0, fo = 0, io = 0, slow = 0;
  logic [7:0] a = 0, wd = 0, rdata, lo, hi;
  logic [31:0] cnt;
  logic [2:0] pio;
  logic [1:0] udt, sts;
  logic beat, req, oe, act, done, cen, rok, skp, dis, gsd, srt, pbad, wide;
  int err_total = 0, checks_done = 0, seed = 32'h0b140904, beats, k;
  dcc_dma_count_config DUT (.clock_i(clk), .srst_i(rst), .reg_addr_i(a), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .master_mode_i(ms),
    .xfer_start_i(st), .xfer_stop_i(sp), .xfer_beat_i(beat), .fifo_ok_i(fo),
    .iordy_i(io), .dma_request_line_o(req), .dma_request_line_oe_o(oe),
    .xfer_active_o(act), .xfer_done_o(done), .count_enabled_o(cen), .ready_ok_o(rok),
    .skip_ready_wait_o(skp), .disk_interface_select_o(dis), .generic_slave_dma_o(gsd),
    .udma_timing_o(udt), .strobe_reg_timing_o(srt), .programmed_io_timing_o(pio),
    .pio_code_bad_o(pbad), .strobe_select_o(sts), .wide_bus_o(wide));
  dcc_far_model u_far (.clock_i(clk), .srst_i(rst), .req_i(req), .oe_i(oe),
    .slow_i(slow), .beat_o(beat));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    #2 fo = ($random(seed) & 3) != 0;
    io = 1'($random(seed));
  end
  always @(posedge clk) if (beat === 1'b1 && act === 1'b1) beats++;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  task wr8(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    #2 a = ad;
    wd = d;
    wr = 1;
    @(posedge clk);
    #2 wr = 0;
  endtask
  task rd8(input logic [7:0] ad, input logic [7:0] e, input string s);
    @(posedge clk);
    #2 a = ad;
    rd = 1;
    @(posedge clk);
    #2 rd = 0;
    chk(s, {24'h0, e}, {24'h0, rdata});
  endtask
  task final_report;
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #2 rst = 0;
    begin : run
    rd8(DCC_ADDR_CFG_LO, 8'h01, "cfg_lo");
    rd8(DCC_ADDR_CFG_HI, 8'h00, "cfg_hi");
    rd8(DCC_ADDR_CNT_B1, 8'h00, "cnt_b1_rst");
    rd8(DCC_ADDR_CNT_B2, 8'h00, "cnt_b2_rst");
    chk("oe_rst", 0, oe);
    for (int i = 0; i < 7; i++) begin
      lo = (8'($random(seed)) & 8'h05) | 8'(i << 4);
      hi = (8'($random(seed)) & 8'h58) | 8'($unsigned($random(seed)) % 5);
      cnt = (32'($random(seed)) & 32'h1f) | 32'h1;
      slow = 1'($random(seed));
      wr8(DCC_ADDR_CFG_LO, lo);
      wr8(DCC_ADDR_CFG_HI, hi);
      for (int j = 0; j < 4; j++) wr8(DCC_ADDR_CNT_B1 + 8'(j), cnt[8*j+:8]);
      rd8(DCC_ADDR_CNT_B1, cnt[7:0], "cnt_b1");
      rd8(DCC_ADDR_CFG_HI, hi, "cfg_hi_rb");
      chk("gsd", 1, gsd);
      chk("pio", 32'(hi[2:0]), 32'(pio));
      chk("pbad", 32'(hi[2:0] > 3'h4), 32'(pbad));
      chk("udt", 32'(hi[4:3]), 32'(udt));
      chk("skp", 32'(hi[6]), 32'(skp));
      if (hi[6]) chk("rok", 1, rok);
      chk("wide", 32'(lo[0]), 32'(wide));
      chk("sts", 32'(lo[3:2]), 32'(sts));
      beats = 0;
      @(posedge clk);
      #2 st = 1;
      @(posedge clk);
      #2 st = 0;
      k = 0;
      while (done !== 1'b1 && k < 600) begin
        @(posedge clk);
        #1 k++;
      end
      if (k >= 600) begin
        err_total++;
        disable run;
      end
      chk("beats", lo[0] ? (cnt + 1) / 2 : cnt, 32'(beats));
      rd8(DCC_ADDR_CNT_B1, 8'h00, "cnt_end");
    end
    // abort a running transfer, the count keeps what is left
    beats = 0;
    for (int j = 0; j < 4; j++) wr8(DCC_ADDR_CNT_B1 + 8'(j), j == 1 ? 8'h01 : 8'h00);
    @(posedge clk);
    #2 st = 1;
    @(posedge clk);
    #2 st = 0;
    repeat (12) @(posedge clk);
    #2 sp = 1;
    @(posedge clk);
    #2 sp = 0;
    chk("act_stop", 0, act);
    chk("done_stop", 0, done);
    cnt = 32'h100 - (lo[0] ? 32'(2 * beats) : 32'(beats));
    rd8(DCC_ADDR_CNT_B1, cnt[7:0], "cnt_stop_b1");
    rd8(DCC_ADDR_CNT_B2, cnt[15:8], "cnt_stop_b2");
    chk("req_stop", 0, req);
    // bus reset after the aborted transfer, count cleared to zero
    @(posedge clk);
    #2 rst = 1;
    repeat (3) @(posedge clk);
    #2 rst = 0;
    rd8(DCC_ADDR_CNT_B1, 8'h00, "cnt_b1_bus_rst");
    rd8(DCC_ADDR_CFG_LO, 8'h01, "cfg_lo_bus_rst");
    chk("oe_bus_rst", 0, oe);
    wr8(DCC_ADDR_CFG_LO, 8'h81);
    chk("cen_slave", 0, cen);
    ms = 1;
    #1 chk("cen_master", 1, cen);
    @(posedge clk);
    #2 ms = 0;
    wr8(DCC_ADDR_CFG_HI, 8'h38);
    chk("srt", 1, srt);
    chk("dis", 1, dis);
    chk("gsd_disk", 0, gsd);
    chk("cen_disk", 1, cen);
    end
    final_report;
  end
endmodule
bind dcc_dma_count_config dcc_dma_count_config_properties u_props (.clock_i(clock_i),
  .srst_i(srst_i), .master_mode_i(master_mode_i), .fifo_ok_i(fifo_ok_i),
  .reg_rdata_o(reg_rdata_o), .dma_request_line_o(dma_request_line_o),
  .dma_request_line_oe_o(dma_request_line_oe_o), .xfer_active_o(xfer_active_o),
  .xfer_done_o(xfer_done_o), .count_enabled_o(count_enabled_o), .ready_ok_o(ready_ok_o),
  .skip_ready_wait_o(skip_ready_wait_o), .disk_interface_select_o(disk_interface_select_o),
  .generic_slave_dma_o(generic_slave_dma_o), .udma_timing_o(udma_timing_o),
  .strobe_reg_timing_o(strobe_reg_timing_o), .programmed_io_timing_o(programmed_io_timing_o),
  .pio_code_bad_o(pio_code_bad_o), .wide_bus_o(wide_bus_o));
